// ---- rtl/oeb_pkg.sv ----
// Purpose: Constants for the out endpoint buffer layout block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Byte offsets and field positions live here; the bench repeats offsets and the iso bit as literals
`default_nettype none
package oeb_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int MEM_AW = 11;
	localparam int END_W = 12;
	localparam int UNIT_SHIFT = 3;
	localparam logic [ADDR_W-1:0] OFF_SIZE = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_X_BASE = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_Y_BASE = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_CONFIG = 12'h00c;
	localparam logic [ADDR_W-1:0] OFF_X_END = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_Y_END = 12'h014;
	localparam logic [REG_W-1:0] RST_SIZE = 8'h00;
	localparam logic [REG_W-1:0] RST_BASE = 8'h00;
	localparam logic [REG_W-1:0] RST_CONFIG = 8'h00;
	localparam int CFG_ISO_BIT = 6;
	localparam logic [UNIT_SHIFT-1:0] LOW_ZERO = 3'h0;
	localparam logic [END_W-MEM_AW-1:0] END_PAD = 1'h0;
	localparam logic [DATA_W-REG_W-1:0] RD_PAD8 = 24'h000000;
	localparam logic [DATA_W-END_W-1:0] RD_PAD12 = 20'h00000;
	typedef enum logic {OEB_BUF_X, OEB_BUF_Y} oeb_buf_t;
endpackage
`default_nettype wire

// ---- rtl/oeb_top.sv ----
// Purpose: Out endpoint X/Y buffer size and base address logic with APB access
// Assumes: Inputs synchronous to pclk, zero-wait APB slave
// Notes: Byte address generation for the endpoint buffer manager
// Operation
// R1: Eight-bit read/write buffer size register
// R2: X and Y share one length
// R3: Length in bytes is size times eight
// R4: X base register holds address bits ten to three
// R5: Low three start address bits forced zero
// R6: Isochronous endpoints wrap, others flag overflow
// R7: Y base register formed like X base
// R8: Bytes addressed upward, end is start plus length
//
// Added by the designer: the APB interface to the registers and the register offsets.
`default_nettype none
module oeb_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [oeb_pkg::ADDR_W-1:0] paddr,
	input wire logic [oeb_pkg::DATA_W-1:0] pwdata,
	output logic [oeb_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ubm_buf_sel,
	input wire logic [oeb_pkg::MEM_AW-1:0] ubm_byte_offset,
	output logic [oeb_pkg::MEM_AW-1:0] ubm_mem_addr,
	output logic ubm_in_range,
	output logic [oeb_pkg::MEM_AW-1:0] x_start_addr,
	output logic [oeb_pkg::MEM_AW-1:0] y_start_addr,
	output logic [oeb_pkg::MEM_AW-1:0] buffer_len_bytes,
	output logic iso_mode
);
	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic [oeb_pkg::MEM_AW-1:0] start_of(
		input logic [oeb_pkg::REG_W-1:0] upper
	);
		start_of = {upper, oeb_pkg::LOW_ZERO}; // R4 R5 R7
	endfunction

	function automatic logic [oeb_pkg::END_W-1:0] end_of(
		input logic [oeb_pkg::MEM_AW-1:0] start,
		input logic [oeb_pkg::MEM_AW-1:0] len
	);
		end_of = {oeb_pkg::END_PAD, start} + {oeb_pkg::END_PAD, len}; // R8
	endfunction

	// ************************************************************
	// Registers
	// ************************************************************
	logic [oeb_pkg::REG_W-1:0] buffer_length_units_reg;
	logic [oeb_pkg::REG_W-1:0] x_start_upper_bits_reg;
	logic [oeb_pkg::REG_W-1:0] y_start_upper_bits_reg;
	logic [oeb_pkg::REG_W-1:0] out_ep_configuration_reg;
	logic [oeb_pkg::DATA_W-1:0] prdata_reg;
	logic [oeb_pkg::DATA_W-1:0] prdata_next;
	logic [oeb_pkg::MEM_AW-1:0] mem_addr_reg;
	logic [oeb_pkg::MEM_AW-1:0] mem_addr_next;
	logic in_range_reg;
	logic in_range_next;

	// ************************************************************
	// Bus decode
	// ************************************************************
	wire logic setup_ph = psel && !penable;
	wire logic hit_size = paddr == oeb_pkg::OFF_SIZE;
	wire logic hit_xb = paddr == oeb_pkg::OFF_X_BASE;
	wire logic hit_yb = paddr == oeb_pkg::OFF_Y_BASE;
	wire logic hit_cfg = paddr == oeb_pkg::OFF_CONFIG;
	wire logic hit_xe = paddr == oeb_pkg::OFF_X_END;
	wire logic hit_ye = paddr == oeb_pkg::OFF_Y_END;
	wire logic hit_rw = hit_size || hit_xb || hit_yb || hit_cfg;
	wire logic hit_any = hit_rw || hit_xe || hit_ye;
	wire logic access = psel && penable;
	wire logic wr_en = access && pwrite && hit_rw;

	// ************************************************************
	// Layout
	// ************************************************************
	wire logic [oeb_pkg::MEM_AW-1:0] len_bytes =
		{buffer_length_units_reg, oeb_pkg::LOW_ZERO}; // R2 R3
	wire logic [oeb_pkg::MEM_AW-1:0] x_start = start_of(x_start_upper_bits_reg);
	wire logic [oeb_pkg::MEM_AW-1:0] y_start = start_of(y_start_upper_bits_reg);
	wire logic [oeb_pkg::END_W-1:0] x_end = end_of(x_start, len_bytes);
	wire logic [oeb_pkg::END_W-1:0] y_end = end_of(y_start, len_bytes);
	wire logic iso = out_ep_configuration_reg[oeb_pkg::CFG_ISO_BIT];
	wire logic [oeb_pkg::MEM_AW-1:0] sel_start =
		(ubm_buf_sel == oeb_pkg::OEB_BUF_Y) ? y_start : x_start;
	wire logic off_over = ubm_byte_offset >= len_bytes;
	wire logic [oeb_pkg::MEM_AW-1:0] wrapped_off = off_over ?
		ubm_byte_offset - len_bytes : ubm_byte_offset; // R6
	wire logic [oeb_pkg::MEM_AW-1:0] eff_off = iso ? wrapped_off : ubm_byte_offset; // R6
	wire logic wrap_ok = !iso || (wrapped_off < len_bytes);

	// ************************************************************
	// Next values
	// ************************************************************
	always_comb begin
		mem_addr_next = sel_start + eff_off; // R8
		in_range_next = (len_bytes != {oeb_pkg::MEM_AW{1'b0}}) &&
			(iso ? wrap_ok : !off_over); // R6 R8
		prdata_next = {oeb_pkg::DATA_W{1'b0}};
		if (setup_ph && !pwrite) begin
			if (hit_size) begin
				prdata_next = {oeb_pkg::RD_PAD8, buffer_length_units_reg}; // R1
			end else if (hit_xb) begin
				prdata_next = {oeb_pkg::RD_PAD8, x_start_upper_bits_reg}; // R4
			end else if (hit_yb) begin
				prdata_next = {oeb_pkg::RD_PAD8, y_start_upper_bits_reg}; // R7
			end else if (hit_cfg) begin
				prdata_next = {oeb_pkg::RD_PAD8, out_ep_configuration_reg};
			end else if (hit_xe) begin
				prdata_next = {oeb_pkg::RD_PAD12, x_end}; // R8
			end else if (hit_ye) begin
				prdata_next = {oeb_pkg::RD_PAD12, y_end}; // R8
			end
		end else if (access) begin
			prdata_next = prdata_reg;
		end
	end

	// ************************************************************
	// Flip-flops
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buffer_length_units_reg <= oeb_pkg::RST_SIZE;
			x_start_upper_bits_reg <= oeb_pkg::RST_BASE;
			y_start_upper_bits_reg <= oeb_pkg::RST_BASE;
			out_ep_configuration_reg <= oeb_pkg::RST_CONFIG;
		end else if (wr_en) begin
			if (hit_size) begin
				buffer_length_units_reg <= pwdata[oeb_pkg::REG_W-1:0]; // R1
			end
			if (hit_xb) begin
				x_start_upper_bits_reg <= pwdata[oeb_pkg::REG_W-1:0]; // R4
			end
			if (hit_yb) begin
				y_start_upper_bits_reg <= pwdata[oeb_pkg::REG_W-1:0]; // R7
			end
			if (hit_cfg) begin
				out_ep_configuration_reg <= pwdata[oeb_pkg::REG_W-1:0]; // R6
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= {oeb_pkg::DATA_W{1'b0}};
			mem_addr_reg <= {oeb_pkg::MEM_AW{1'b0}};
			in_range_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			mem_addr_reg <= mem_addr_next;
			in_range_reg <= in_range_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = access && (!hit_any || (pwrite && !hit_rw));
	assign ubm_mem_addr = mem_addr_reg;
	assign ubm_in_range = in_range_reg;
	assign x_start_addr = x_start;
	assign y_start_addr = y_start;
	assign buffer_len_bytes = len_bytes;
	assign iso_mode = iso;

	// ************************************************************
	// Checks
	// ************************************************************
	chk_size_write: assert property (@(posedge pclk) disable iff (!presetn) // R1
		(wr_en && hit_size) |=>
		buffer_len_bytes == {$past(pwdata[oeb_pkg::REG_W-1:0]), oeb_pkg::LOW_ZERO})
		else $error("size write not applied");

	chk_size_hold: assert property (@(posedge pclk) disable iff (!presetn) // R1
		!(wr_en && hit_size) |=> $stable(buffer_len_bytes))
		else $error("size changed without write");

	chk_len_shared: assert property (@(posedge pclk) disable iff (!presetn) // R2
		(x_end - {oeb_pkg::END_PAD, x_start_addr}) ==
		(y_end - {oeb_pkg::END_PAD, y_start_addr}))
		else $error("x and y lengths differ");

	chk_len_units: assert property (@(posedge pclk) disable iff (!presetn) // R3
		buffer_len_bytes[oeb_pkg::UNIT_SHIFT-1:0] == oeb_pkg::LOW_ZERO &&
		buffer_len_bytes[oeb_pkg::MEM_AW-1:oeb_pkg::UNIT_SHIFT] == buffer_length_units_reg)
		else $error("length not eight times size");

	chk_xbase_write: assert property (@(posedge pclk) disable iff (!presetn) // R4
		(wr_en && hit_xb) |=> x_start_addr[oeb_pkg::MEM_AW-1:oeb_pkg::UNIT_SHIFT] ==
		$past(pwdata[oeb_pkg::REG_W-1:0]))
		else $error("x base write not applied");

	chk_low_zero: assert property (@(posedge pclk) disable iff (!presetn) // R5
		x_start_addr[oeb_pkg::UNIT_SHIFT-1:0] == oeb_pkg::LOW_ZERO &&
		y_start_addr[oeb_pkg::UNIT_SHIFT-1:0] == oeb_pkg::LOW_ZERO)
		else $error("start address not aligned");

	chk_ybase_write: assert property (@(posedge pclk) disable iff (!presetn) // R7
		(wr_en && hit_yb) |=> y_start_addr[oeb_pkg::MEM_AW-1:oeb_pkg::UNIT_SHIFT] ==
		$past(pwdata[oeb_pkg::REG_W-1:0]))
		else $error("y base write not applied");

	chk_nonis_range: assert property (@(posedge pclk) disable iff (!presetn) // R6
		(!iso && ubm_byte_offset >= buffer_len_bytes) |=> !ubm_in_range)
		else $error("overflow offset reported in range");

	chk_addr_upward: assert property (@(posedge pclk) disable iff (!presetn) // R8
		(!iso && ubm_buf_sel == oeb_pkg::OEB_BUF_X) |=>
		ubm_mem_addr == $past(x_start_addr) + $past(ubm_byte_offset))
		else $error("x byte address wrong");

	chk_iso_wrap: assert property (@(posedge pclk) disable iff (!presetn) // R6
		(iso && ubm_byte_offset >= buffer_len_bytes
		&& buffer_len_bytes != {oeb_pkg::MEM_AW{1'b0}}
		&& ubm_buf_sel == oeb_pkg::OEB_BUF_Y) |=> ubm_mem_addr == $past(y_start_addr)
		+ $past(ubm_byte_offset) - $past(buffer_len_bytes))
		else $error("iso wrap address wrong");

	chk_end_refused: assert property (@(posedge pclk) disable iff (!presetn) // R8
		(access && pwrite && (hit_xe || hit_ye)) |-> pslverr)
		else $error("end register write not refused");

	chk_zero_len: assert property (@(posedge pclk) disable iff (!presetn) // R8
		(buffer_len_bytes == {oeb_pkg::MEM_AW{1'b0}}) |=> !ubm_in_range)
		else $error("zero length reported in range");
endmodule
`default_nettype wire

// ---- dv/oeb_top_tb_top.sv ----
// Purpose: Self-checking bench for the out endpoint buffer layout block
// Assumes: Zero-wait APB slave, one-cycle buffer manager latency
// Notes: Directed sequences only, outputs read right after the sampling edge
`default_nettype none
module oeb_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [oeb_pkg::ADDR_W-1:0] paddr = 12'h000;
	logic [oeb_pkg::DATA_W-1:0] pwdata = 32'h00000000;
	logic [oeb_pkg::DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic ubm_buf_sel = 1'b0;
	logic [oeb_pkg::MEM_AW-1:0] ubm_byte_offset = 11'h000;
	logic [oeb_pkg::MEM_AW-1:0] ubm_mem_addr, x_start_addr, y_start_addr, buffer_len_bytes;
	logic ubm_in_range;
	logic iso_mode;
	logic [31:0] rd;
	logic err;
	logic [11:0] offs [3] = '{12'h000, 12'h004, 12'h008};
	logic [7:0] vals [3] = '{8'h18, 8'hff, 8'h81};
	int err_count = 0;
	int total_checks = 0;
	always #20 pclk = ~pclk;
	oeb_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ubm_buf_sel(ubm_buf_sel), .ubm_byte_offset(ubm_byte_offset),
		.ubm_mem_addr(ubm_mem_addr), .ubm_in_range(ubm_in_range), .x_start_addr(x_start_addr),
		.y_start_addr(y_start_addr), .buffer_len_bytes(buffer_len_bytes), .iso_mode(iso_mode));
	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task tally_and_finish;
		$display("Checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			tally_and_finish();
		end
	endtask
	task endpoint_buffer_manager(input logic s, input logic [10:0] off, input logic [10:0] ea, input logic ei);
		@(posedge pclk);
		ubm_buf_sel <= s;
		ubm_byte_offset <= off;
		repeat (2) @(posedge pclk);
		chk("ubm_mem_addr", {21'h0, ubm_mem_addr}, {21'h0, ea});
		chk("ubm_in_range", {31'h0, ubm_in_range}, {31'h0, ei});
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, offs[i], 32'h0);
			chk("reset value", rd, 32'h0);
		end
		chk("reset in range", {31'h0, ubm_in_range}, 32'h0);
		chk("reset iso", {31'h0, iso_mode}, 32'h0);
		chk("reset length", {21'h0, buffer_len_bytes}, 32'h0);
		$display("Test reset values done");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, offs[i], {24'hffffff, vals[i]});
			apb(1'b0, offs[i], 32'h0);
			chk("register readback", rd, {24'h0, vals[i]});
			chk("readback error", {31'h0, err}, 32'h0);
		end
		@(posedge pclk);
		chk("buffer_len_bytes", {21'h0, buffer_len_bytes}, 32'd192);
		chk("x_start_addr", {21'h0, x_start_addr}, 32'h7f8);
		chk("y_start_addr", {21'h0, y_start_addr}, 32'h408);
		$display("Test register fields done");
		apb(1'b1, 12'h000, 32'h02);
		apb(1'b1, 12'h004, 32'h10);
		apb(1'b1, 12'h008, 32'h20);
		endpoint_buffer_manager(1'b0, 11'd15, 11'h08f, 1'b1);
		endpoint_buffer_manager(1'b0, 11'd16, 11'h090, 1'b0);
		endpoint_buffer_manager(1'b1, 11'd15, 11'h10f, 1'b1);
		endpoint_buffer_manager(1'b1, 11'd16, 11'h110, 1'b0);
		apb(1'b1, 12'h00c, 32'h40);
		@(posedge pclk);
		chk("iso_mode", {31'h0, iso_mode}, 32'h1);
		endpoint_buffer_manager(1'b0, 11'd17, 11'h081, 1'b1);
		endpoint_buffer_manager(1'b1, 11'd40, 11'h118, 1'b0);
		$display("Test buffer manager done");
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, 12'h010, 32'h55);
		chk("end write error", {31'h0, err}, 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		chk("x end", rd, 32'h090);
		apb(1'b0, 12'h014, 32'h0);
		chk("y end", rd, 32'h110);
		$display("Test refusals done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
